// *** rtl/tdx_top.sv ***
// Top of the converter serial load and receive gain setup block.
// Notes on behaviour
// - Converter is ten bits, loaded only serially.
// - Converter-select high routes frames to converter.
// - Frame bits 15..6 are code; rest discarded.
// - Code applied when chip select rises.
// - Input amplifier gains 0.25, 0.5, 1, 2.
// - Output amplifier gains 1, 4, 16, 64.
// - Control bit 3 picks filter cutoff band.
// - Data launched falling, captured rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tdx_top
(
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          sel_n,
  input  wire logic                          sdi,
  input  wire logic                          conv_sel,
  output logic                               sdo,
  output logic     [tdx_pkg::CODE_W-1:0]     tx_converter_code,
  output logic                               conv_mode,
  output logic                               band_cutoff_select,
  output tdx_pkg::tdx_in_gain_t              rx_input_amplifier,
  output tdx_pkg::tdx_out_gain_t             rx_output_amplifier,
  output logic     [tdx_pkg::DATA_W-1:0]     block_power_switches
);

  // ----------------------------------------------------------------
  // Serial capture
  // ----------------------------------------------------------------
  // The serial clock is the block clock; shifting happens on its rising edge only.
  logic [tdx_pkg::FRAME_W-1:0] frame;       // Bits shifted so far.
  logic [tdx_pkg::CNT_W-1:0]   count;       // Bits counted in this frame.

  tdx_shift u_shift
  (
    .clk      (clk),
    .rstn     (rstn),
    .sel_n    (sel_n),
    .sdi      (sdi),
    .frame_ff (frame),
    .count_ff (count)
  );

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  logic        sel_n_ff;     // Chip select one edge ago, for the rising edge.
  logic        to_conv_ff;   // Converter-select was seen high at some sample during this frame.
  logic        nxt_sel_n;
  logic        nxt_to_conv;
  logic        frame_end;    // Chip select just rose.
  logic        full;         // A whole frame of bits was taken.

  assign frame_end = sel_n && !sel_n_ff;
  assign full      = (count == tdx_pkg::CNT_W'(tdx_pkg::FRAME_W));

  // The route is latched while select is low: the host raises converter-select after
  // lowering chip select, so any sample taken during the frame counts.
  always_comb
  begin
    nxt_sel_n   = sel_n;
    nxt_to_conv = to_conv_ff;
    if (sel_n)
    begin
      if (frame_end)
      begin
        nxt_to_conv = 1'b0;
      end
    end
    else if (conv_sel)
    begin
      nxt_to_conv = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_n_ff   <= 1'b1;
      to_conv_ff <= 1'b0;
    end
    else
    begin
      sel_n_ff   <= nxt_sel_n;
      to_conv_ff <= nxt_to_conv;
    end
  end

  // ----------------------------------------------------------------
  // Converter code and control registers
  // ----------------------------------------------------------------
  logic [tdx_pkg::CODE_W-1:0] code_ff;     // Applied converter code.
  logic [tdx_pkg::DATA_W-1:0] switch_ff;   // Block power switches.
  logic [tdx_pkg::DATA_W-1:0] gain_ff;     // Gain select.
  logic [tdx_pkg::DATA_W-1:0] band_ff;     // Band and status control.
  logic [tdx_pkg::CODE_W-1:0] nxt_code;
  logic [tdx_pkg::DATA_W-1:0] nxt_switch;
  logic [tdx_pkg::DATA_W-1:0] nxt_gain;
  logic [tdx_pkg::DATA_W-1:0] nxt_band;
  logic [5:0]                 addr;        // Address of a control frame.
  logic                       is_write;    // Control frame is a write.

  assign addr     = frame[tdx_pkg::ADDR_MSB:tdx_pkg::ADDR_LSB];
  assign is_write = !frame[tdx_pkg::RW_BIT];

  // A short frame is dropped whole so a glitched select never corrupts state.
  always_comb
  begin
    nxt_code   = code_ff;      // Hold until a later complete frame.
    nxt_switch = switch_ff;
    nxt_gain   = gain_ff;
    nxt_band   = band_ff;
    if (frame_end && full)
    begin
      if (to_conv_ff)
      begin
        // Left-justified; bits below the code are thrown away.
        nxt_code = frame[tdx_pkg::CODE_MSB:tdx_pkg::CODE_LSB];
      end
      else if (is_write)
      begin
        if (addr == tdx_pkg::ADDR_SWITCHES)
        begin
          nxt_switch = frame[tdx_pkg::DATA_W-1:0];
        end
        else if (addr == tdx_pkg::ADDR_GAIN)
        begin
          nxt_gain = frame[tdx_pkg::DATA_W-1:0];
        end
        else if (addr == tdx_pkg::ADDR_BAND)
        begin
          nxt_band = frame[tdx_pkg::DATA_W-1:0];
        end
        else
        begin
          nxt_band = band_ff;  // Unmapped writes are ignored.
        end
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      code_ff   <= tdx_pkg::RST_CODE;
      switch_ff <= tdx_pkg::RST_SWITCHES;
      gain_ff   <= tdx_pkg::RST_GAIN;
      band_ff   <= tdx_pkg::RST_BAND;
    end
    else
    begin
      code_ff   <= nxt_code;
      switch_ff <= nxt_switch;
      gain_ff   <= nxt_gain;
      band_ff   <= nxt_band;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic                  conv_mode_ff;
  logic                  band_out_ff;
  logic                  sdo_ff;        // Serial output, kept low.
  tdx_pkg::tdx_in_gain_t  in_gain_ff;
  tdx_pkg::tdx_out_gain_t out_gain_ff;
  logic                  nxt_conv_mode;
  logic                  nxt_band_out;
  logic                  nxt_sdo;
  tdx_pkg::tdx_in_gain_t  nxt_in_gain;
  tdx_pkg::tdx_out_gain_t nxt_out_gain;

  // Converter mode needs the pin and the enable bit; otherwise the path takes pulse input.
  always_comb
  begin
    nxt_conv_mode = conv_sel && switch_ff[tdx_pkg::CONV_EN_BIT];
    nxt_band_out  = band_ff[tdx_pkg::BAND_BIT];   // 0 = lowest band, 1 = upper bands.
    nxt_in_gain   = tdx_pkg::tdx_in_gain_t'(gain_ff[tdx_pkg::IN_GAIN_LSB+:2]);
    nxt_out_gain  = tdx_pkg::tdx_out_gain_t'(gain_ff[tdx_pkg::OUT_GAIN_LSB+:2]);
    nxt_sdo       = 1'b0;   // Read-back is outside this block, so the line stays low.
  end

  // Registers only.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_mode_ff <= 1'b0;
      band_out_ff  <= 1'b0;
      sdo_ff       <= 1'b0;
      // Gains mirror the gain register's reset value so no step is shown that it never held.
      in_gain_ff   <= tdx_pkg::tdx_in_gain_t'(tdx_pkg::RST_GAIN[tdx_pkg::IN_GAIN_LSB+:2]);
      out_gain_ff  <= tdx_pkg::tdx_out_gain_t'(tdx_pkg::RST_GAIN[tdx_pkg::OUT_GAIN_LSB+:2]);
    end
    else
    begin
      conv_mode_ff <= nxt_conv_mode;
      band_out_ff  <= nxt_band_out;
      sdo_ff       <= nxt_sdo;
      in_gain_ff   <= nxt_in_gain;
      out_gain_ff  <= nxt_out_gain;
    end
  end

  assign tx_converter_code    = code_ff;
  assign conv_mode            = conv_mode_ff;
  assign band_cutoff_select   = band_out_ff;
  assign rx_input_amplifier   = in_gain_ff;
  assign rx_output_amplifier  = out_gain_ff;
  assign block_power_switches = switch_ff;
  assign sdo                  = sdo_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_conv_frame_done;
    frame_end && full && to_conv_ff;
  endsequence

  chk_code_load: assert property (@(posedge clk) disable iff (!rstn)
    s_conv_frame_done |=>
      tx_converter_code == $past(frame[tdx_pkg::CODE_MSB:tdx_pkg::CODE_LSB]))
    else $error("converter code not loaded from frame");

  chk_code_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(frame_end && full && to_conv_ff) |=> $stable(tx_converter_code))
    else $error("converter code changed without a frame");

  chk_route_ctrl: assert property (@(posedge clk) disable iff (!rstn)
    s_conv_frame_done |=> $stable(switch_ff) && $stable(gain_ff) && $stable(band_ff))
    else $error("converter frame touched control registers");

  chk_band_out: assert property (@(posedge clk) disable iff (!rstn)
    ##1 band_cutoff_select == $past(band_ff[tdx_pkg::BAND_BIT]))
    else $error("band select does not follow control bit");

  chk_conv_mode: assert property (@(posedge clk) disable iff (!rstn)
    ##1 conv_mode == ($past(conv_sel) && $past(switch_ff[tdx_pkg::CONV_EN_BIT])))
    else $error("converter mode wrong");

  chk_in_gain: assert property (@(posedge clk) disable iff (!rstn)
    ##1 rx_input_amplifier == $past(gain_ff[tdx_pkg::IN_GAIN_LSB+:2]))
    else $error("input amplifier gain wrong");

  chk_out_gain: assert property (@(posedge clk) disable iff (!rstn)
    ##1 rx_output_amplifier == $past(gain_ff[tdx_pkg::OUT_GAIN_LSB+:2]))
    else $error("output amplifier gain wrong");

  chk_short_drop: assert property (@(posedge clk) disable iff (!rstn)
    (frame_end && !full) |=> $stable(tx_converter_code) && $stable(gain_ff))
    else $error("short frame was applied");

endmodule
`default_nettype wire

// *** rtl/tdx_pkg.sv ***
// Package of constants for the transmit converter serial load and receive gain setup block.
`default_nettype none
package tdx_pkg;

  // ----------------------------------------------------------------
  // Frame and converter geometry
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_W   = 16;   // Bits in one serial frame.
  localparam int unsigned CODE_W    = 10;   // Converter resolution.
  localparam int unsigned CODE_MSB  = 15;   // Frame bit holding converter bit 9.
  localparam int unsigned CODE_LSB  = 6;    // Frame bit holding converter bit 0.
  localparam int unsigned CNT_W     = 5;    // Width of the frame bit counter.

  // ----------------------------------------------------------------
  // Control frame layout (read/write bit, address, data)
  // ----------------------------------------------------------------
  localparam int unsigned RW_BIT    = 15;   // Read = 1, write = 0.
  localparam int unsigned ADDR_MSB  = 13;   // Top of the six address bits.
  localparam int unsigned ADDR_LSB  = 8;    // Bottom of the address bits.
  localparam int unsigned DATA_W    = 8;    // Data bits in a control frame.

  // ----------------------------------------------------------------
  // Control register addresses and fields
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_SWITCHES = 6'h01; // Block power switches.
  localparam logic [5:0] ADDR_GAIN     = 6'h02; // Receive input and output amplifier gain select.
  localparam logic [5:0] ADDR_BAND     = 6'h04; // Band and status control.
  localparam logic [7:0] RST_SWITCHES  = 8'h00; // Power switches after reset.
  localparam logic [7:0] RST_GAIN      = 8'h32; // Gain select after reset.
  localparam logic [7:0] RST_BAND      = 8'h00; // Band control after reset.
  localparam int unsigned CONV_EN_BIT  = 5;     // Converter enable in the power switches.
  localparam int unsigned BAND_BIT     = 3;     // Filter cutoff in the band control.
  localparam int unsigned IN_GAIN_LSB  = 0;     // Input amplifier gain field.
  localparam int unsigned OUT_GAIN_LSB = 2;     // Output amplifier gain field.
  localparam logic [9:0] RST_CODE      = 10'h200; // Midscale converter code.

  // Gain step codes of the two receive amplifiers.
  typedef enum logic [1:0] {IN_G_0P25, IN_G_0P5, IN_G_1, IN_G_2} tdx_in_gain_t;
  typedef enum logic [1:0] {OUT_G_1, OUT_G_4, OUT_G_16, OUT_G_64} tdx_out_gain_t;

endpackage
`default_nettype wire

// *** rtl/tdx_shift.sv ***
// Serial input shift register with bit counter, sampled on rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module tdx_shift
(
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         sel_n,
  input  wire logic                         sdi,
  output logic     [tdx_pkg::FRAME_W-1:0]   frame_ff,
  output logic     [tdx_pkg::CNT_W-1:0]     count_ff
);

  // ----------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------
  logic [tdx_pkg::FRAME_W-1:0] nxt_frame;  // Shifted frame.
  logic [tdx_pkg::CNT_W-1:0]   nxt_count;  // Bits taken this frame.

  // Shift MSB first while selected; the counter saturates so extra bits only shift.
  always_comb
  begin
    nxt_frame = frame_ff;
    nxt_count = count_ff;
    if (sel_n)
    begin
      nxt_count = '0;
    end
    else
    begin
      nxt_frame = {frame_ff[tdx_pkg::FRAME_W-2:0], sdi};
      if (count_ff != tdx_pkg::CNT_W'(tdx_pkg::FRAME_W))
      begin
        nxt_count = count_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Registers only.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      frame_ff <= nxt_frame;
      count_ff <= nxt_count;
    end
  end

endmodule
`default_nettype wire

// *** test/tdx_host.sv ***
// Behavioural host that shifts frames into the block over the serial port.
`timescale 1ns/1ps
`default_nettype none
module tdx_host
(
  input  wire logic clk,
  output logic      sel_n,
  output logic      sdi,
  output logic      conv_sel
);
  // Idle lines: deselected, converter select low.
  initial
  begin
    sel_n    = 1'b1;
    sdi      = 1'b0;
    conv_sel = 1'b0;
  end

  // Shift nb bits of f, first bit f[15], all launched on falling edges.
  // The edge between select low and the first bit samples a filler bit.
  // The block keeps only the last sixteen, so a whole frame survives it.
  task automatic send(input logic [15:0] f, input logic cv, input int nb);
    @(negedge clk);
    sel_n = 1'b0;
    sdi   = ~sdi;
    @(negedge clk);
    conv_sel = cv;
    for (int i = 0; i < nb; i++)
    begin
      if (i > 0) @(negedge clk);
      sdi = f[15 - i];
    end
    @(negedge clk);
    sel_n = 1'b1;
    sdi   = ~sdi; // A released data line must not look held.
    @(negedge clk);
    conv_sel = 1'b0;
  endtask

  // Park the converter select level between frames.
  task automatic park(input logic v);
    @(negedge clk);
    conv_sel = v;
  endtask
endmodule
`default_nettype wire

// *** test/tx_dac_serial_load_and_rx_gain_setup_tb.sv ***
// Self-checking bench for the converter load and receive setup block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
module tx_dac_serial_load_and_rx_gain_setup_tb;
  // ----------------------------------------------------------------
  // Signals and expected state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [9:0] code;
    logic [7:0] sw;
    logic [7:0] gain;
    logic [7:0] band;
    logic       cm;
  } tdx_exp_t;

  logic                         clk, rstn, sel_n, sdi, conv_sel, sdo;
  logic                         conv_mode, band_cutoff_select;
  logic [9:0]                   tx_converter_code;
  logic [7:0]                   block_power_switches;
  tdx_pkg::tdx_in_gain_t        rx_input_amplifier;
  tdx_pkg::tdx_out_gain_t       rx_output_amplifier;
  tdx_exp_t                     e, got;
  tdx_exp_t                     exp_q[$];
  event                         chk_ev;
  int                           err_count, n_compared;

  tdx_host host_u (.clk(clk), .sel_n(sel_n), .sdi(sdi), .conv_sel(conv_sel));

  tdx_top dut_u
  (
    .clk(clk), .rstn(rstn), .sel_n(sel_n), .sdi(sdi), .conv_sel(conv_sel), .sdo(sdo),
    .tx_converter_code(tx_converter_code), .conv_mode(conv_mode),
    .band_cutoff_select(band_cutoff_select), .rx_input_amplifier(rx_input_amplifier),
    .rx_output_amplifier(rx_output_amplifier), .block_power_switches(block_power_switches)
  );

  // Clock at 250 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Let derived outputs settle two cycles, then hand the note over.
  task automatic note();
    repeat (2) @(negedge clk);
    exp_q.push_back(e);
    ->chk_ev;
  endtask

  // Control frame; only writes to the three kept addresses land.
  task automatic ctrl(input logic rw, input logic [5:0] a, input logic [7:0] d);
    host_u.send({rw, 1'b0, a, d}, 1'b0, 16);
    if (rw == 1'b0 && a == tdx_pkg::ADDR_SWITCHES) e.sw = d;
    if (rw == 1'b0 && a == tdx_pkg::ADDR_GAIN) e.gain = d;
    if (rw == 1'b0 && a == tdx_pkg::ADDR_BAND) e.band = d;
    note();
  endtask

  // Converter frame; a short one must leave the code alone.
  task automatic conv(input logic [15:0] f, input int nb);
    host_u.send(f, 1'b1, nb);
    if (nb == 16) e.code = f[15:6];
    note();
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitor: compares each settled result with the oldest note
  // ----------------------------------------------------------------
  initial
  begin
    forever
    begin
      @(chk_ev);
      got = exp_q.pop_front();
      `CHK(tx_converter_code, got.code)
      `CHK(block_power_switches, got.sw)
      `CHK(rx_input_amplifier, got.gain[1:0])
      `CHK(rx_output_amplifier, got.gain[3:2])
      `CHK(band_cutoff_select, got.band[3])
      `CHK(conv_mode, got.cm)
      `CHK(sdo, 1'b0)
    end
  end

  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial
  begin
    #20000;
    err_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn       = 1'b0;
    err_count  = 0;
    n_compared = 0;
    e = '{code: 10'h200, sw: 8'h00, gain: 8'h32, band: 8'h00, cm: 1'b0};
    void'($urandom(32'h9634c01b));
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    note();
    ctrl(1'b0, tdx_pkg::ADDR_SWITCHES, 8'h20);
    host_u.park(1'b1);
    e.cm = 1'b1;
    note();
    host_u.park(1'b0);
    e.cm = 1'b0;
    note();
    // Pin high without the enable bit must not select converter mode.
    ctrl(1'b0, tdx_pkg::ADDR_SWITCHES, 8'h1f);
    host_u.park(1'b1);
    note();
    host_u.park(1'b0);
    note();
    // Every step of both amplifiers, in opposite orders.
    for (int i = 0; i < 4; i++)
      ctrl(1'b0, tdx_pkg::ADDR_GAIN, {4'h5, 2'(3 - i), 2'(i)});
    ctrl(1'b0, tdx_pkg::ADDR_BAND, 8'h08);
    ctrl(1'b0, tdx_pkg::ADDR_BAND, 8'hf7);
    ctrl(1'b1, tdx_pkg::ADDR_GAIN, 8'h00);
    ctrl(1'b0, 6'h3f, 8'hff);
    // Converter frames: extremes, a control look-alike, then random.
    conv(16'hffc0, 16);
    conv(16'h003f, 16);
    conv(16'h01ff, 16);
    for (int k = 0; k < 6; k++)
      conv(16'($urandom), 16);
    conv(16'h5555, 14);
    summarize();
  end
endmodule
`default_nettype wire
